// ---- panel_scan_cfg.svh ----
// Configuration constants for the operation-panel scan matrix I/O block
`ifndef PANEL_SCAN_CFG_SVH
`define PANEL_SCAN_CFG_SVH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
`define CLK_MHZ 250
`define SCAN_IN_PERIOD_US 11680
`define SCAN_OUT_PERIOD_US 5840
`define SCAN_OUT_SLOT_US 1460
`define CHATTER_US 3000
`define DIN_DELAY_MIN_US 3000
`define DIN_DELAY_MAX_US 16000
`define DIN_TICK_US 1000
`define LADDER_FRAMES 2

// ****************************************************************
// Matrix and station geometry
// ****************************************************************
`define SCAN_IN_COMMONS 8
`define SCAN_OUT_COMMONS 4
`define SCAN_ROW_BITS 8
`define STATION_POINTS 32
`define STATION_SHIFT 5

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_LED 8'h08
`define REG_DOUT 8'h0C
`define REG_SCAN_A 8'h10
`define REG_SCAN_B 8'h14
`define REG_DIN 8'h18
`define REG_STATION 8'h1C
`define EV_SCAN_A 0
`define EV_SCAN_B 1
`define EV_DIN 2
`define EV_ALARM 3
`define EV_BITS 4
`define ALARM_LSB 24
`define RST_MASK 4'h0
`define RST_WORD 32'h00000000

`endif

// ---- panel_scan_pkg.sv ----
// Types shared by the operation-panel scan matrix I/O block
`default_nettype none
package panel_scan_pkg;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // I/O base address of each station group
  typedef struct packed {
    logic [7:0] base_a;
    logic [7:0] base_b;
    logic [7:0] base_d;
  } station_map_t;

  // Scan-output common phase, Gray along the rotation
  typedef enum logic [1:0] {
    OUT_C0 = 2'b00,
    OUT_C1 = 2'b01,
    OUT_C2 = 2'b11,
    OUT_C3 = 2'b10
  } out_phase_t;

endpackage
`default_nettype wire

// ---- pin_sync3.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`default_nettype none
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pin and clean level
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] clean
);
  logic [W-1:0] s1_q, s2_q, s3_q, clean_d;

  if (W < 1) begin : g_bad_width
    $error("pin_sync3 needs a width of one or more");
  end

  always_comb begin
    clean_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & clean);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      clean <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean <= clean_d;
    end
  end
endmodule // pin_sync3
`default_nettype wire

// ---- stab_filter.sv ----
// Per-bit stability filter counted in ticks of a slow enable
`default_nettype none
`timescale 1ns/1ns
module stab_filter #(
  parameter int W = 32,
  parameter int STABLE = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Raw samples and tick
  input wire logic tick,
  input wire logic [W-1:0] raw,
  // Recognised levels and change pulses
  output logic [W-1:0] rec_q,
  output logic [W-1:0] chg_q
);
  localparam int CW = $clog2(STABLE + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE - 1);

  if (STABLE < 1) begin : g_bad
    $error("stab_filter needs STABLE of one or more");
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    logic cand_q, cand_d, rec_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic at_end;

    assign at_end = tick && (raw[i] == cand_q) && (cnt_q == LAST);

    // Any change of the raw level restarts the count
    always_comb begin
      cand_d = cand_q;
      cnt_d = cnt_q;
      rec_d = rec_q[i];
      if (raw[i] != cand_q) begin
        cand_d = raw[i];
        cnt_d = '0;
      end else if (tick) begin
        if (cnt_q == LAST) begin
          rec_d = cand_q; // RQ3 RQ16
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cand_q <= 1'b0;
        cnt_q <= '0;
        rec_q[i] <= 1'b0;
        chg_q[i] <= 1'b0;
      end else begin
        cand_q <= cand_d;
        cnt_q <= cnt_d;
        rec_q[i] <= rec_d;
        chg_q[i] <= rec_d ^ rec_q[i];
      end
    end

    a_filter_hold: assert property ($changed(rec_q[i]) |-> $past(at_end)) // RQ3
      else $error("recognised level changed before it was stable");
    a_filter_pulse: assert property ($changed(rec_q[i]) |-> chg_q[i] ##1 !chg_q[i]) // RQ12
      else $error("change pulse missing or too long");
  end
endmodule // stab_filter
`default_nettype wire

// ---- panel_scan_matrix_io.sv ----
// Operation-panel scan matrix and direct I/O unit with register port
// How it works
// RQ1 - Key data are taken only at the end of a slot while that row's input common is held low.
// RQ2 - The input commons advance one per slot so all eight complete a round every 11.68 ms.
// RQ3 - An input change that does not last a full recognition window is never published.
// RQ4 - LED data for a row are driven only while that row's output common is high.
// RQ5 - The four output commons go high one after another in a fixed rotation.
// RQ6 - Each output common is high for one 1.46 ms slot and returns every 5.84 ms.
// RQ7 - Three alarm outputs follow the communication error of their station and stay low otherwise.
// RQ8 - Each of the three station groups carries 32 input and 32 output points; here the two scan groups share one 32-point LED output matrix.
// RQ9 - Each group's I/O base address comes from its station selector, so moving the selector moves it.
// RQ10 - The installer gives the three selectors distinct station numbers from 0 to 7.
// RQ11 - The installer normally sets the scan selectors to 0 and 1 and the direct selector to 2.
// RQ12 - Contact chatter of up to 3 ms on the direct inputs gives no recognised transition.
// RQ13 - The direct input delay lies between 3 ms and 16 ms, the same for on and off.
// RQ14 - External contacts hold each state about 40 ms or more.
// RQ15 - The key matrix has eight commons and eight data lines, one byte per common.
// RQ16 - All scanned and direct samples pass a stability filter on the internal timebase.
//
// Chosen here: the strobed register port and the address map.
`include "panel_scan_cfg.svh"
`default_nettype none
`timescale 1ns/1ns
module panel_scan_matrix_io import panel_scan_pkg::*; #(
  parameter int SLOT_CYCLES = `SCAN_OUT_SLOT_US * `CLK_MHZ,
  parameter int DIN_TICK_CYCLES = `DIN_TICK_US * `CLK_MHZ,
  parameter int DIN_STABLE_TICKS = `CHATTER_US / `DIN_TICK_US + 2,
  parameter int SCAN_STABLE_FRAMES = `LADDER_FRAMES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire reg_req_t bus_req,
  output logic [31:0] rd_data,
  output logic irq,
  // Scan input matrix
  output logic [7:0] scan_in_common_n,
  input wire logic [7:0] scan_in_data_n,
  // Scan output matrix
  output logic [3:0] scan_out_common,
  output logic [7:0] scan_out_data_n,
  // Direct digital I/O
  input wire logic [31:0] din,
  output logic [31:0] dout,
  // Station selectors and link status
  input wire logic [2:0] scan_station_sel_a,
  input wire logic [2:0] scan_station_sel_b,
  input wire logic [2:0] direct_io_station_sel,
  input wire logic [2:0] comm_err,
  // Station assignment and alarms
  output station_map_t station_map,
  output logic alarm_scan_a,
  output logic alarm_scan_b,
  output logic alarm_direct_io
);
  // ****************************************************************
  // Derived constants and elaboration checks
  // ****************************************************************
  localparam int SW = $clog2(SLOT_CYCLES);
  localparam int DW = $clog2(DIN_TICK_CYCLES);
  localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYCLES - 1);
  localparam logic [DW-1:0] DIN_LAST = DW'(DIN_TICK_CYCLES - 1);
  localparam logic [2:0] IN_LAST = 3'(`SCAN_IN_COMMONS - 1);
  localparam int ROWS_OUT = `SCAN_OUT_COMMONS;

  if (SLOT_CYCLES < 2 || DIN_TICK_CYCLES < 2 || SCAN_STABLE_FRAMES < 1) begin : g_bad_count
    $error("panel_scan_matrix_io count parameters too small");
  end
  // One slot serves both matrices: 8 input slots and 4 output slots
  if (`SCAN_IN_PERIOD_US != `SCAN_IN_COMMONS * `SCAN_OUT_SLOT_US ||
      `SCAN_OUT_PERIOD_US != ROWS_OUT * `SCAN_OUT_SLOT_US) begin : g_bad_slot
    $error("scan periods do not match the common slot"); // RQ2 RQ6
  end
  if ((DIN_STABLE_TICKS - 1) * `DIN_TICK_US <= `CHATTER_US ||
      (DIN_STABLE_TICKS - 1) * `DIN_TICK_US < `DIN_DELAY_MIN_US ||
      (DIN_STABLE_TICKS + 1) * `DIN_TICK_US > `DIN_DELAY_MAX_US) begin : g_bad_delay
    $error("direct input filter outside chatter and delay limits"); // RQ12 RQ13
  end

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [1:0] phase_idx(input out_phase_t p);
    case (p)
      OUT_C0: phase_idx = 2'h0;
      OUT_C1: phase_idx = 2'h1;
      OUT_C2: phase_idx = 2'h2;
      default: phase_idx = 2'h3;
    endcase
  endfunction

  function automatic logic [7:0] led_row(input logic [31:0] led, input logic [1:0] idx);
    led_row = led[idx * `SCAN_ROW_BITS +: `SCAN_ROW_BITS];
  endfunction

  function automatic logic [7:0] base_of(input logic [2:0] sel);
    base_of = {sel, `STATION_SHIFT'(0)}; // RQ8 RQ9
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [7:0] key_n_s;
  logic [31:0] din_s;
  logic [8:0] sel_s;

  pin_sync3 #(.W(8), .RST_VAL(8'hFF)) u_key_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in(scan_in_data_n),
    .clean(key_n_s)
  );

  pin_sync3 #(.W(32), .RST_VAL(32'h00000000)) u_din_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in(din),
    .clean(din_s)
  );

  pin_sync3 #(.W(9), .RST_VAL(9'h000)) u_sel_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in({direct_io_station_sel, scan_station_sel_b, scan_station_sel_a}),
    .clean(sel_s)
  );

  // ****************************************************************
  // Timebase and matrix scanning
  // ****************************************************************
  logic [SW-1:0] slot_cnt_q, slot_cnt_d;
  logic [DW-1:0] din_cnt_q, din_cnt_d;
  logic slot_tick, din_tick_q, din_tick_d;
  logic [2:0] in_idx_q, in_idx_d;
  out_phase_t out_phase_q, out_phase_d;
  logic [63:0] raw_scan_q, raw_scan_d;
  logic frame_tick_q, frame_tick_d;
  logic [7:0] scan_in_common_n_d, scan_out_data_n_d;
  logic [3:0] scan_out_common_d;
  logic [31:0] led_q;

  assign slot_tick = (slot_cnt_q == SLOT_LAST);

  always_comb begin
    slot_cnt_d = slot_tick ? '0 : slot_cnt_q + SW'(1);
    din_tick_d = (din_cnt_q == DIN_LAST);
    din_cnt_d = din_tick_d ? '0 : din_cnt_q + DW'(1);
    in_idx_d = in_idx_q;
    out_phase_d = out_phase_q;
    raw_scan_d = raw_scan_q;
    frame_tick_d = 1'b0;
    if (slot_tick) begin
      // Sample at slot end: the row line has long settled low
      raw_scan_d[in_idx_q * `SCAN_ROW_BITS +: `SCAN_ROW_BITS] = ~key_n_s; // RQ1 RQ15
      frame_tick_d = (in_idx_q == IN_LAST);
      in_idx_d = in_idx_q + 3'h1; // RQ2
      case (out_phase_q)
        OUT_C0: out_phase_d = OUT_C1;
        OUT_C1: out_phase_d = OUT_C2;
        OUT_C2: out_phase_d = OUT_C3;
        default: out_phase_d = OUT_C0;
      endcase // RQ5 RQ6
    end
    scan_in_common_n_d = ~(8'h01 << in_idx_d); // RQ15
    scan_out_common_d = 4'h1 << phase_idx(out_phase_d); // RQ5
    // Active-low data of the row whose common is high
    scan_out_data_n_d = ~led_row(led_q, phase_idx(out_phase_d)); // RQ4
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slot_cnt_q <= '0;
      din_cnt_q <= '0;
      din_tick_q <= 1'b0;
      in_idx_q <= 3'h0;
      out_phase_q <= OUT_C0;
      raw_scan_q <= 64'h0000000000000000;
      frame_tick_q <= 1'b0;
      scan_in_common_n <= 8'hFE;
      scan_out_common <= 4'h1;
      scan_out_data_n <= 8'hFF;
    end else begin
      slot_cnt_q <= slot_cnt_d;
      din_cnt_q <= din_cnt_d;
      din_tick_q <= din_tick_d;
      in_idx_q <= in_idx_d;
      out_phase_q <= out_phase_d;
      raw_scan_q <= raw_scan_d;
      frame_tick_q <= frame_tick_d;
      scan_in_common_n <= scan_in_common_n_d;
      scan_out_common <= scan_out_common_d;
      scan_out_data_n <= scan_out_data_n_d;
    end
  end

  // ****************************************************************
  // Recognition filters
  // ****************************************************************
  logic [63:0] scan_rec, scan_chg;
  logic [31:0] din_rec, din_chg;

  // Scan rows refresh once per frame, so the window counts whole frames
  stab_filter #(.W(64), .STABLE(SCAN_STABLE_FRAMES)) u_scan_filt (
    .mclk(mclk),
    .rst(rst),
    .tick(frame_tick_q),
    .raw(raw_scan_q),
    .rec_q(scan_rec),
    .chg_q(scan_chg)
  ); // RQ3 RQ16

  // Inputs are active high after synchronisation: contact closed reads 1
  stab_filter #(.W(32), .STABLE(DIN_STABLE_TICKS)) u_din_filt (
    .mclk(mclk),
    .rst(rst),
    .tick(din_tick_q),
    .raw(din_s),
    .rec_q(din_rec),
    .chg_q(din_chg)
  ); // RQ12 RQ13 RQ16

  // ****************************************************************
  // Registers, events and alarms
  // ****************************************************************
  logic [`EV_BITS-1:0] status_q, status_d, mask_q, mask_d, events;
  logic [31:0] led_d, dout_d, rd_data_d;
  logic [2:0] alarm_q, alarm_d;
  station_map_t station_map_d;
  logic irq_d, status_rd;

  always_comb begin
    alarm_d = comm_err; // RQ7
    station_map_d.base_a = base_of(sel_s[2:0]); // RQ9
    station_map_d.base_b = base_of(sel_s[5:3]);
    station_map_d.base_d = base_of(sel_s[8:6]);
    events = '0;
    events[`EV_SCAN_A] = |scan_chg[`STATION_POINTS-1:0];
    events[`EV_SCAN_B] = |scan_chg[2*`STATION_POINTS-1:`STATION_POINTS];
    events[`EV_DIN] = |din_chg;
    events[`EV_ALARM] = |(alarm_d & ~alarm_q);
    status_rd = bus_req.rd && (bus_req.addr == `REG_STATUS);
    // A new event in the clearing read cycle stays set
    status_d = (status_rd ? '0 : status_q) | events;
    mask_d = mask_q;
    led_d = led_q;
    dout_d = dout;
    if (bus_req.wr) begin
      if (bus_req.addr == `REG_MASK) begin
        mask_d = bus_req.wdata[`EV_BITS-1:0];
      end else if (bus_req.addr == `REG_LED) begin
        led_d = bus_req.wdata;
      end else if (bus_req.addr == `REG_DOUT) begin
        dout_d = bus_req.wdata;
      end
    end
    rd_data_d = `RST_WORD;
    if (bus_req.rd) begin
      if (bus_req.addr == `REG_STATUS) begin
        rd_data_d = 32'(status_q);
      end else if (bus_req.addr == `REG_MASK) begin
        rd_data_d = 32'(mask_q);
      end else if (bus_req.addr == `REG_LED) begin
        rd_data_d = led_q;
      end else if (bus_req.addr == `REG_DOUT) begin
        rd_data_d = dout;
      end else if (bus_req.addr == `REG_SCAN_A) begin
        rd_data_d = scan_rec[`STATION_POINTS-1:0];
      end else if (bus_req.addr == `REG_SCAN_B) begin
        rd_data_d = scan_rec[2*`STATION_POINTS-1:`STATION_POINTS];
      end else if (bus_req.addr == `REG_DIN) begin
        rd_data_d = din_rec;
      end else if (bus_req.addr == `REG_STATION) begin
        rd_data_d = {5'h00, alarm_q, station_map};
      end
    end
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
      mask_q <= `RST_MASK;
      led_q <= `RST_WORD;
      dout <= `RST_WORD;
      rd_data <= `RST_WORD;
      alarm_q <= 3'h0;
      station_map <= '0;
      irq <= 1'b0;
      alarm_scan_a <= 1'b0;
      alarm_scan_b <= 1'b0;
      alarm_direct_io <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      led_q <= led_d;
      dout <= dout_d;
      rd_data <= rd_data_d;
      alarm_q <= alarm_d;
      station_map <= station_map_d;
      irq <= irq_d;
      alarm_scan_a <= alarm_d[0];
      alarm_scan_b <= alarm_d[1];
      alarm_direct_io <= alarm_d[2];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_key_sample_low: assert property (slot_tick |-> !scan_in_common_n[in_idx_q]) // RQ1
    else $error("key row sampled while its common was not low");
  a_in_one_low: assert property ($onehot(~scan_in_common_n)) // RQ15
    else $error("input commons not exactly one low");
  a_in_advance: assert property ($changed(scan_in_common_n) |-> $past(slot_tick)) // RQ2
    else $error("input common moved off the slot boundary");
  a_in_rotate: assert property (slot_tick |=> scan_in_common_n == {$past(scan_in_common_n[6:0]),
      $past(scan_in_common_n[7])}) // RQ2
    else $error("input common did not step to the next row");
  a_out_rotate: assert property (slot_tick |=> scan_out_common == {$past(scan_out_common[2:0]),
      $past(scan_out_common[3])}) // RQ5
    else $error("output common did not step in rotation");
  a_out_slot_hold: assert property ($changed(scan_out_common) |-> $past(slot_tick)) // RQ6
    else $error("output common changed inside a slot");
  a_led_gated: assert property ($stable(led_q) |-> $onehot(scan_out_common) && scan_out_data_n == // RQ4
      ~led_row(led_q, {scan_out_common[3] | scan_out_common[2], scan_out_common[3] | scan_out_common[1]}))
    else $error("LED data not those of the active output common");
  a_alarm_follow: assert property ($rose(comm_err[2]) |=> alarm_direct_io ##1 $stable(alarm_direct_io)
      or !comm_err[2]) // RQ7
    else $error("direct station alarm did not follow its error");
  a_alarm_quiet: assert property (!comm_err[0] && !comm_err[1] |=> !alarm_scan_a && !alarm_scan_b) // RQ7
    else $error("scan alarm lit without a communication error");
  a_station_base: assert property ($changed(sel_s) |=> station_map.base_d == {$past(sel_s[8:6]),
      `STATION_SHIFT'(0)}) // RQ9
    else $error("direct group base does not follow its selector");

  c_frame_done: cover property (frame_tick_q);
  c_key_seen: cover property ($rose(scan_rec[15]));
  c_din_seen: cover property ($rose(din_rec[0]));
  c_irq_raise: cover property ($rose(irq));
endmodule // panel_scan_matrix_io
`default_nettype wire

// ---- panel_key_model.sv ----
// Key matrix model with one diode per key and pulled-up data lines
`default_nettype none
`timescale 1ns/1ns
module panel_key_model (
  // Matrix wiring
  input wire logic [7:0] common_n,
  input wire logic [63:0] pressed,
  output logic [7:0] data_n
);
  // Pull-ups hold idle lines high; diodes stop sneak paths between rows
  always_comb begin
    data_n = 8'hFF;
    for (int r = 0; r < 8; r++) begin
      if (common_n[r] === 1'b0) begin
        data_n = data_n & ~pressed[r*8 +: 8];
      end
    end
  end
endmodule // panel_key_model
`default_nettype wire

// ---- test_panel_scan_matrix_io.sv ----
// Self-checking testbench for the panel scan matrix I/O block
`default_nettype none
`timescale 1ns/1ns
module test_panel_scan_matrix_io import panel_scan_pkg::*;;
  // Short slots and ticks keep the run brief
  localparam int SLOT = 16;
  localparam int TICK = 8;
  localparam logic [31:0] LED = 32'h81422418;
  logic mclk, rst, irq, alarm_scan_a, alarm_scan_b, alarm_direct_io;
  reg_req_t bus_req;
  logic [31:0] rd_data, din, dout, rv;
  logic [7:0] scan_in_common_n, scan_in_data_n, scan_out_data_n, c;
  logic [3:0] scan_out_common;
  logic [2:0] sel_a, sel_b, sel_d, comm_err;
  station_map_t station_map;
  logic [63:0] pressed;
  int miscompares, tests_run, cyc, n, r;

  panel_scan_matrix_io #(.SLOT_CYCLES(SLOT), .DIN_TICK_CYCLES(TICK)) DUT (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .irq(irq),
    .scan_in_common_n(scan_in_common_n), .scan_in_data_n(scan_in_data_n),
    .scan_out_common(scan_out_common), .scan_out_data_n(scan_out_data_n),
    .din(din), .dout(dout), .scan_station_sel_a(sel_a), .scan_station_sel_b(sel_b),
    .direct_io_station_sel(sel_d), .comm_err(comm_err), .station_map(station_map),
    .alarm_scan_a(alarm_scan_a), .alarm_scan_b(alarm_scan_b), .alarm_direct_io(alarm_direct_io)
  );

  panel_key_model keys (.common_n(scan_in_common_n), .pressed(pressed), .data_n(scan_in_data_n));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ****
  // Checking and bus tasks
  // ****
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    #1;
    rv = rd_data;
  endtask

  function automatic logic [7:0] vw(input bit s);
    return s ? {4'h0, scan_out_common} : scan_in_common_n;
  endfunction

  // Cycles until the selected common set next changes
  task automatic step(input bit s, output int k);
    logic [7:0] c0;
    c0 = vw(s);
    k = 0;
    while (vw(s) === c0 && k < 1000) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      complete_run;
    end
  end

  // ****
  // Main sequence
  // ****
  initial begin
    rst = 1'b1;
    bus_req = '0;
    din = 32'h0;
    comm_err = 3'h0;
    pressed = 64'h0;
    cyc = 0;
    sel_a = 3'h0;
    sel_b = 3'h1;
    sel_d = 3'h2;
    repeat (16) @(posedge mclk);
    chk({scan_in_common_n, scan_out_data_n, 4'h0, scan_out_common, 8'h00}, 32'hFEFF0100);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk({8'h00, station_map}, 32'h00002040);
    rd(8'h20);
    chk(rv, 32'h0);
    wr(8'h0C, 32'hC35A5AC3);
    rd(8'h0C);
    chk(rv, 32'hC35A5AC3);
    chk(dout, 32'hC35A5AC3);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C);
    chk(rv, 32'h00002040);
    // Input commons walk one slot each
    step(1'b0, n);
    for (int k = 0; k < 8; k++) begin
      c = vw(1'b0);
      step(1'b0, n);
      chk({24'h0, vw(1'b0)}, {24'h0, c[6:0], c[7]});
      chk(n, SLOT);
    end
    wr(8'h08, LED);
    step(1'b1, n);
    for (int k = 0; k < 4; k++) begin
      c = vw(1'b1);
      step(1'b1, n);
      chk({24'h0, vw(1'b1)}, {28'h0, c[2:0], c[3]});
      chk(n, SLOT);
      for (int j = 0; j < 4; j++) if (scan_out_common[j]) r = j;
      chk({24'h0, scan_out_data_n}, {24'h0, ~LED[8*r +: 8]});
    end
    // A one-slot tap must vanish; long presses are recognised
    pressed <= 64'h1;
    repeat (SLOT) @(posedge mclk);
    pressed <= (64'h1 << 43) | (64'h1 << 15);
    repeat (6*8*SLOT) @(posedge mclk);
    rd(8'h10);
    chk(rv, 32'h00008000);
    rd(8'h14);
    chk(rv, 32'h00000800);
    pressed <= 64'h0;
    repeat (6*8*SLOT) @(posedge mclk);
    rd(8'h10);
    chk(rv, 32'h0);
    rd(8'h00);
    wr(8'h04, 32'h0);
    // Chatter of three ticks that settles back low
    for (int k = 0; k < 6; k++) begin
      din <= {31'h0, ~k[0]};
      repeat (TICK/2) @(posedge mclk);
    end
    repeat (20*TICK) @(posedge mclk);
    rd(8'h18);
    chk(rv, 32'h0);
    din <= 32'hA5A50001;
    repeat (3*TICK-2) @(posedge mclk);
    rd(8'h18);
    chk(rv, 32'h0);
    repeat (13*TICK) @(posedge mclk);
    rd(8'h18);
    chk(rv, 32'hA5A50001);
    chk({31'h0, irq}, 32'h0);
    wr(8'h04, 32'h4);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    rd(8'h00);
    chk(rv, 32'h4);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    din <= 32'h0;
    repeat (3*TICK-2) @(posedge mclk);
    rd(8'h18);
    chk(rv, 32'hA5A50001);
    repeat (13*TICK) @(posedge mclk);
    rd(8'h18);
    chk(rv, 32'h0);
    for (int v = 0; v < 8; v++) begin
      comm_err <= v[2:0];
      repeat (3) @(posedge mclk);
      #1;
      chk({29'h0, alarm_direct_io, alarm_scan_b, alarm_scan_a}, v);
      rd(8'h1C);
      chk(rv, {5'h0, v[2:0], 24'h002040});
    end
    comm_err <= 3'h0;
    rd(8'h00);
    chk(rv, 32'hC);
    // Moving the selectors moves every group
    sel_a <= 3'h7;
    sel_b <= 3'h3;
    sel_d <= 3'h5;
    repeat (8) @(posedge mclk);
    #1;
    chk({8'h00, station_map}, 32'h00E060A0);
    rd(8'h1C);
    chk(rv, 32'h00E060A0);
    complete_run;
  end
endmodule // test_panel_scan_matrix_io
`default_nettype wire
